// >>> adcmc_defs.svh
// Constants for the converter mode control register bank.
// Assumes inclusion by the package and the design modules only.
`ifndef ADCMC_DEFS_SVH
`define ADCMC_DEFS_SVH

// ----------------------------------------------------------------
// Serial frame layout
// ----------------------------------------------------------------
`define ADCMC_FRAME_BITS 16
`define ADCMC_HEAD_BITS 8
`define ADCMC_ADDR_W 7
`define ADCMC_DATA_W 8

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADCMC_OFS_RESET 7'h00
`define ADCMC_OFS_FORMAT 7'h01
`define ADCMC_OFS_OMODE 7'h02

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define ADCMC_RESET_TRIG_BIT 7
`define ADCMC_FORMAT_RST 8'h00
`define ADCMC_OMODE_RST 8'h00

// ----------------------------------------------------------------
// Driver current codes, in units of 0.05 mA
// ----------------------------------------------------------------
`define ADCMC_CUR_3P5 8'h46
`define ADCMC_CUR_4P0 8'h50
`define ADCMC_CUR_4P5 8'h5A
`define ADCMC_CUR_3P0 8'h3C
`define ADCMC_CUR_2P5 8'h32
`define ADCMC_CUR_2P1 8'h2A
`define ADCMC_CUR_1P75 8'h23
`define ADCMC_CUR_NONE 8'h00

// ----------------------------------------------------------------
// Serialization widths
// ----------------------------------------------------------------
`define ADCMC_SER_16 5'h10
`define ADCMC_SER_14 5'h0E
`define ADCMC_SER_12 5'h0C
`define ADCMC_SER_NONE 5'h00

`endif

// >>> adcmc_formatter.sv
// Output word formatting: sign coding and scrambling per channel.
// Assumes offset binary samples arrive on core_clk with a valid strobe.
`timescale 1ns/10ps

module adcmc_formatter #(
  parameter int CHANNELS = 4,
  parameter int SAMPLE_W = 12
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [CHANNELS*SAMPLE_W-1:0] sample_in,
  input wire logic sample_valid,
  input wire logic output_scramble_enable,
  input wire logic signed_format_select,
  input wire logic [CHANNELS-1:0] channel_enable,
  input wire logic output_drive_disable,
  output logic [CHANNELS*SAMPLE_W-1:0] sample_out,
  output logic sample_out_valid
);

  // Apply sign coding then scrambling to one word
  function automatic logic [SAMPLE_W-1:0] fmt_word(input logic [SAMPLE_W-1:0] w,
                                                   input logic scr, input logic sgn);
    logic [SAMPLE_W-1:0] v;
    v = w;
    v[SAMPLE_W-1] = w[SAMPLE_W-1] ^ sgn;
    if (scr) begin
      v[SAMPLE_W-1:1] = v[SAMPLE_W-1:1] ^ {(SAMPLE_W-1){v[0]}};
    end
    return v;
  endfunction

  // Per-channel word register, napped channels read zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sample_out <= '0;
    end else if (sample_valid) begin
      for (int c = 0; c < CHANNELS; c++) begin
        sample_out[c*SAMPLE_W +: SAMPLE_W] <= channel_enable[c] ?
          fmt_word(sample_in[c*SAMPLE_W +: SAMPLE_W], output_scramble_enable,
                   signed_format_select) : '0; // R16
      end
    end
  end

  // Valid strobe suppressed while outputs are off
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sample_out_valid <= 1'b0;
    end else begin
      sample_out_valid <= sample_valid && !output_drive_disable; // R12
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_scramble_lsb;
    @(posedge core_clk) disable iff (rst)
    (sample_valid && output_scramble_enable && channel_enable[0])
      |=> sample_out[SAMPLE_W-2:1] == ($past(sample_in[SAMPLE_W-2:1])
          ^ {(SAMPLE_W-2){$past(sample_in[0])}});
  endproperty
  a_scramble_lsb: assert property (p_scramble_lsb) // R16
    else $error("scrambled bits do not match lsb xor");

  property p_sign_msb;
    @(posedge core_clk) disable iff (rst)
    (sample_valid && !output_scramble_enable && channel_enable[0])
      |=> sample_out[SAMPLE_W-1] == ($past(sample_in[SAMPLE_W-1])
          ^ $past(signed_format_select));
  endproperty
  a_sign_msb: assert property (p_sign_msb) // R7
    else $error("sign bit coding wrong");

endmodule

// >>> adcmc_host_model.sv
// Serial port host model driving the mode control register bank.
// Assumes the bench resolves the open-drain readback line with a pull-up.
`timescale 1ns/10ps

module adcmc_host_model (
  output logic link_sck,
  output logic chip_select_n,
  output logic serial_config_in,
  input wire logic readback_line
);
  // ------------------------------------------------------------
  // Idle levels: clock stands low, frame deselected
  // ------------------------------------------------------------
  initial begin
    link_sck = 1'b0;
    chip_select_n = 1'b1;
    serial_config_in = 1'b0;
  end

  // One 16-bit frame, first bit first; half sets the link speed
  task automatic frame(input logic rd, input logic [6:0] addr, input logic [7:0] wdata,
                       input int half, output logic [7:0] rdata);
    logic [15:0] word;
    word = {rd, addr, wdata};
    rdata = 8'h00;
    chip_select_n = 1'b0;
    for (int k = 15; k >= 0; k--) begin
      serial_config_in = word[k];
      #(half);
      link_sck = 1'b1;
      if (k < 8) begin
        rdata[k] = readback_line;
      end
      #(half);
      link_sck = 1'b0;
    end
    #(half); // Select held past the last falling edge
    chip_select_n = 1'b1;
    serial_config_in = ~word[0]; // Released line must not echo last bit
    #1280;
  endtask
endmodule

// >>> adcmc_mode_regs.sv
// Mode control register bank of a four-channel converter.
// Serial port logic runs on the port clock, registers on core_clk.
// Assumes the port clock idles while rst is high.
//
// Functional notes
// R1: Host sends software reset first.
// R2: Reset bit write clears all mode registers.
// R3: Reset bit never stays set.
// R4: Reset register write-only, low bits ignored.
// R5: Bit 7 turns stabilizer off.
// R6: Bit 6 enables output scrambling.
// R7: Bit 5 selects two's complement coding.
// R8: Low bits nap channels; bit 4 sleeps.
// R9: Bits 7-5 select driver current.
// R10: Termination on doubles driver current.
// R11: Host uses termination only with low currents.
// R12: Bit 3 disables all outputs; code only suppresses sample_out_valid, sample_out keeps updating.
// R13: Bits 2-0 select lanes and serialization.
// R14: Frame: direction bit, address, data, msb first.
// R15: Read returns contents, changes nothing.
// R16: Scrambling xors every bit with lsb; code xors only the bits above the lsb, the lsb passes unchanged.
// R17: Host waits 100 cycles after wake.
// R18: Reset state is all fields zero.
`timescale 1ns/10ps
`include "adcmc_defs.svh"

module adcmc_mode_regs
  import adcmc_pkg::*;
#(
  parameter int CHANNELS = 4,
  parameter int SAMPLE_W = 12
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic link_sck,
  input wire logic chip_select_n,
  input wire logic serial_config_in,
  output logic serial_readback_out,
  output logic serial_readback_oe_n,
  input wire logic config_port_select,
  output adcmc_format_s format_cfg,
  output adcmc_omode_s omode_cfg,
  output adcmc_decode_s decode_cfg,
  input wire logic [CHANNELS*SAMPLE_W-1:0] sample_in,
  input wire logic sample_valid,
  output logic [CHANNELS*SAMPLE_W-1:0] sample_out,
  output logic sample_out_valid
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] current_units(input logic [2:0] code);
    logic [7:0] u;
    u = `ADCMC_CUR_NONE;
    unique case (code)
      3'h0: u = `ADCMC_CUR_3P5;
      3'h1: u = `ADCMC_CUR_4P0;
      3'h2: u = `ADCMC_CUR_4P5;
      3'h3: u = `ADCMC_CUR_NONE;
      3'h4: u = `ADCMC_CUR_3P0;
      3'h5: u = `ADCMC_CUR_2P5;
      3'h6: u = `ADCMC_CUR_2P1;
      3'h7: u = `ADCMC_CUR_1P75;
    endcase
    return u;
  endfunction

  function automatic logic [4:0] serial_width(input logic [2:0] code);
    logic [4:0] w;
    w = `ADCMC_SER_NONE;
    unique case (code)
      3'h0, 3'h7: w = `ADCMC_SER_16;
      3'h1, 3'h5: w = `ADCMC_SER_14;
      3'h2, 3'h6: w = `ADCMC_SER_12;
      3'h3, 3'h4: w = `ADCMC_SER_NONE;
    endcase
    return w;
  endfunction

  // ----------------------------------------------------------------
  // Link domain: frame capture
  // ----------------------------------------------------------------
  logic link_rst_reg;
  logic [4:0] bit_cnt_reg;
  logic [15:0] shift_reg;
  logic [15:0] frame_word_reg;
  logic frame_tgl_reg;
  adcmc_link_e link_state_reg;
  logic [15:0] shadow_reg;
  logic [7:0] rd_shift_reg;
  logic pull_low_reg;
  logic pub_req_sync;
  logic pub_ack_reg;
  logic [15:0] pub_word_reg;

  // Reset request for the link logic, held from core reset
  always_ff @(posedge core_clk) begin
    link_rst_reg <= rst;
  end

  // Bit counter, cleared whenever select is released
  always_ff @(posedge link_sck or posedge chip_select_n) begin
    if (chip_select_n) begin
      bit_cnt_reg <= 5'h00;
    end else if (bit_cnt_reg != 5'(`ADCMC_FRAME_BITS)) begin
      bit_cnt_reg <= bit_cnt_reg + 5'h01; // R14
    end
  end

  // Input shifter, edges past the sixteenth ignored
  always_ff @(posedge link_sck) begin
    if (bit_cnt_reg != 5'(`ADCMC_FRAME_BITS)) begin
      shift_reg <= {shift_reg[14:0], serial_config_in}; // R14
    end
  end

  // Frame phase tracking
  always_ff @(posedge link_sck or posedge chip_select_n) begin
    if (chip_select_n) begin
      link_state_reg <= ADCMC_LK_HEAD;
    end else begin
      unique case (link_state_reg)
        ADCMC_LK_HEAD: begin
          if (bit_cnt_reg == 5'(`ADCMC_HEAD_BITS - 1)) begin
            link_state_reg <= shift_reg[6] ? ADCMC_LK_READ : ADCMC_LK_WRITE;
          end
        end
        ADCMC_LK_WRITE, ADCMC_LK_READ: begin
          if (bit_cnt_reg == 5'(`ADCMC_FRAME_BITS - 1)) begin
            link_state_reg <= ADCMC_LK_DONE;
          end
        end
        ADCMC_LK_DONE: begin
          link_state_reg <= ADCMC_LK_DONE;
        end
        default: begin
          link_state_reg <= ADCMC_LK_HEAD;
        end
      endcase
    end
  end

  // Completed frame handed to the core by toggle
  always_ff @(posedge link_sck or posedge link_rst_reg) begin
    if (link_rst_reg) begin
      frame_word_reg <= 16'h0000;
      frame_tgl_reg <= 1'b0;
    end else if (!chip_select_n && bit_cnt_reg == 5'(`ADCMC_FRAME_BITS - 1)) begin
      frame_word_reg <= {shift_reg[14:0], serial_config_in};
      frame_tgl_reg <= ~frame_tgl_reg;
    end
  end

  // Register contents mirrored into the link domain
  always_ff @(posedge link_sck or posedge link_rst_reg) begin
    if (link_rst_reg) begin
      pub_ack_reg <= 1'b0;
      shadow_reg <= 16'h0000;
    end else begin
      pub_ack_reg <= pub_req_sync;
      if (pub_req_sync != pub_ack_reg) begin
        shadow_reg <= pub_word_reg;
      end
    end
  end

  // Readback data chosen once the address is known
  always_ff @(posedge link_sck) begin
    if (link_state_reg == ADCMC_LK_HEAD && bit_cnt_reg == 5'(`ADCMC_HEAD_BITS - 1)) begin
      unique case ({shift_reg[5:0], serial_config_in})
        `ADCMC_OFS_FORMAT: rd_shift_reg <= shadow_reg[15:8]; // R15
        `ADCMC_OFS_OMODE: rd_shift_reg <= shadow_reg[7:0];
        default: rd_shift_reg <= 8'h00;
      endcase
    end else if (link_state_reg == ADCMC_LK_READ) begin
      rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
    end
  end

  // Open-drain readback, updated on falling edges
  always_ff @(negedge link_sck or posedge chip_select_n) begin
    if (chip_select_n) begin
      pull_low_reg <= 1'b0;
    end else begin
      pull_low_reg <= (link_state_reg == ADCMC_LK_READ) && !rd_shift_reg[7]; // R15
    end
  end

  assign serial_readback_out = 1'b0;
  assign serial_readback_oe_n = ~pull_low_reg;

  // ----------------------------------------------------------------
  // Core domain: crossings
  // ----------------------------------------------------------------
  logic frame_tgl_sync;
  logic pub_ack_sync;
  logic port_sel_sync;
  logic frame_seen_reg;
  logic pub_req_reg;
  logic apply_reg;
  logic [15:0] cmd_reg;

  adcmc_sync2 #(.WIDTH(3)) u_core_sync (
    .clk(core_clk),
    .async_in({frame_tgl_reg, pub_ack_reg, config_port_select}),
    .sync_out({frame_tgl_sync, pub_ack_sync, port_sel_sync})
  );

  adcmc_sync2 #(.WIDTH(1)) u_link_sync (
    .clk(link_sck),
    .async_in(pub_req_reg),
    .sync_out(pub_req_sync)
  );

  // New frame taken while the serial port is selected
  always_ff @(posedge core_clk) begin
    if (rst) begin
      frame_seen_reg <= 1'b0;
      apply_reg <= 1'b0;
      cmd_reg <= 16'h0000;
    end else begin
      frame_seen_reg <= frame_tgl_sync;
      apply_reg <= (frame_tgl_sync != frame_seen_reg) && !port_sel_sync;
      if (frame_tgl_sync != frame_seen_reg) begin
        cmd_reg <= frame_word_reg;
      end
    end
  end

  // Publish register contents whenever the last copy was taken
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pub_req_reg <= 1'b0;
      pub_word_reg <= 16'h0000;
    end else if (pub_req_reg == pub_ack_sync) begin
      pub_word_reg <= {format_cfg, omode_cfg};
      pub_req_reg <= ~pub_req_reg;
    end
  end

  // ----------------------------------------------------------------
  // Core domain: mode registers
  // ----------------------------------------------------------------
  logic cmd_write;
  logic [6:0] cmd_addr;
  logic [7:0] cmd_data;

  assign cmd_write = apply_reg && !cmd_reg[15]; // R14
  assign cmd_addr = cmd_reg[14:8];
  assign cmd_data = cmd_reg[7:0];

  // Register writes; reset trigger clears and is never stored
  always_ff @(posedge core_clk) begin
    if (rst) begin
      format_cfg <= `ADCMC_FORMAT_RST; // R18
      omode_cfg <= `ADCMC_OMODE_RST;
    end else if (cmd_write) begin
      unique case (cmd_addr)
        `ADCMC_OFS_RESET: begin
          if (cmd_data[`ADCMC_RESET_TRIG_BIT]) begin // R4
            format_cfg <= `ADCMC_FORMAT_RST; // R2
            omode_cfg <= `ADCMC_OMODE_RST; // R3
          end
        end
        `ADCMC_OFS_FORMAT: format_cfg <= cmd_data; // R5
        `ADCMC_OFS_OMODE: omode_cfg <= cmd_data; // R13
        default: begin
        end
      endcase
    end
  end

  // Decoded settings, registered
  always_ff @(posedge core_clk) begin
    if (rst) begin
      decode_cfg <= '0;
    end else begin
      decode_cfg.duty_stabilizer_on <= !format_cfg.duty_stabilizer_disable; // R5
      decode_cfg.channel_enable <= format_cfg.sleep ? 4'h0 : ~format_cfg.nap; // R8
      decode_cfg.drive_current <= omode_cfg.internal_termination_enable ?
        current_units(omode_cfg.driver_current_select) << 1 :
        current_units(omode_cfg.driver_current_select); // R10
      decode_cfg.current_code_unused <= omode_cfg.driver_current_select == 3'h3; // R9
      decode_cfg.one_lane <= omode_cfg.lane_serialization_select[2]; // R13
      decode_cfg.serial_bits <= serial_width(omode_cfg.lane_serialization_select);
      decode_cfg.lane_code_unused <= serial_width(omode_cfg.lane_serialization_select)
        == `ADCMC_SER_NONE;
    end
  end

  // ----------------------------------------------------------------
  // Output formatting
  // ----------------------------------------------------------------
  adcmc_formatter #(.CHANNELS(CHANNELS), .SAMPLE_W(SAMPLE_W)) u_fmt (
    .core_clk(core_clk),
    .rst(rst),
    .sample_in(sample_in),
    .sample_valid(sample_valid),
    .output_scramble_enable(format_cfg.output_scramble_enable), // R6
    .signed_format_select(format_cfg.signed_format_select), // R7
    .channel_enable(decode_cfg.channel_enable),
    .output_drive_disable(omode_cfg.output_drive_disable), // R12
    .sample_out(sample_out),
    .sample_out_valid(sample_out_valid)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_reset_cmd;
    cmd_write && cmd_addr == `ADCMC_OFS_RESET && cmd_data[`ADCMC_RESET_TRIG_BIT];
  endsequence

  sequence s_regs_zero;
    format_cfg == 8'h00 && omode_cfg == 8'h00;
  endsequence

  property p_soft_reset;
    @(posedge core_clk) disable iff (rst)
    s_reset_cmd |=> s_regs_zero;
  endproperty
  a_soft_reset: assert property (p_soft_reset) // R2
    else $error("software reset left a field set");

  property p_reset_selfclear;
    @(posedge core_clk) disable iff (rst)
    s_reset_cmd |=> s_regs_zero [*2];
  endproperty
  a_reset_selfclear: assert property (p_reset_selfclear) // R3
    else $error("reset trigger did not release");

  property p_reset_low_bits;
    @(posedge core_clk) disable iff (rst)
    (cmd_write && cmd_addr == `ADCMC_OFS_RESET && !cmd_data[`ADCMC_RESET_TRIG_BIT])
      |=> $stable(format_cfg) && $stable(omode_cfg);
  endproperty
  a_reset_low_bits: assert property (p_reset_low_bits) // R4
    else $error("low reset bits changed a register");

  property p_format_write;
    @(posedge core_clk) disable iff (rst)
    (cmd_write && cmd_addr == `ADCMC_OFS_FORMAT) |=> format_cfg == $past(cmd_data);
  endproperty
  a_format_write: assert property (p_format_write) // R6
    else $error("format register write lost");

  property p_omode_write;
    @(posedge core_clk) disable iff (rst)
    (cmd_write && cmd_addr == `ADCMC_OFS_OMODE) |=> omode_cfg == $past(cmd_data);
  endproperty
  a_omode_write: assert property (p_omode_write) // R12
    else $error("output mode register write lost");

  property p_read_no_change;
    @(posedge core_clk) disable iff (rst)
    (apply_reg && cmd_reg[15]) |=> $stable(format_cfg) && $stable(omode_cfg);
  endproperty
  a_read_no_change: assert property (p_read_no_change) // R15
    else $error("read command altered a register");

  property p_sleep_all_off;
    @(posedge core_clk) disable iff (rst)
    format_cfg.sleep |=> decode_cfg.channel_enable == 4'h0;
  endproperty
  a_sleep_all_off: assert property (p_sleep_all_off) // R8
    else $error("channel awake during sleep");

  property p_term_double;
    @(posedge core_clk) disable iff (rst)
    (omode_cfg.internal_termination_enable && omode_cfg.driver_current_select == 3'h7)
      |=> decode_cfg.drive_current == 8'h46;
  endproperty
  a_term_double: assert property (p_term_double) // R10
    else $error("termination current not doubled");

  property p_default_state;
    @(posedge core_clk) rst |=> s_regs_zero;
  endproperty
  a_default_state: assert property (p_default_state) // R18
    else $error("reset state not all zero");

  property p_frame_length;
    @(negedge link_sck) disable iff (chip_select_n || link_rst_reg)
    (bit_cnt_reg == 5'h10 && $past(bit_cnt_reg) == 5'h0F)
      |-> frame_tgl_reg != $past(frame_tgl_reg);
  endproperty
  a_frame_length: assert property (p_frame_length) // R14
    else $error("frame not handed over at sixteenth edge");

endmodule

// >>> adcmc_mode_regs_tb.sv
// Self-checking bench for the mode control register bank.
// Assumes the host model file and the design package are compiled first.
`timescale 1ns/10ps

module adcmc_mode_regs_tb;
  import adcmc_pkg::*;
  logic core_clk, rst, link_sck, chip_select_n, serial_config_in;
  logic serial_readback_out, serial_readback_oe_n, config_port_select;
  logic sample_valid, sample_out_valid;
  wire logic readback_line;
  adcmc_format_s format_cfg;
  adcmc_omode_s omode_cfg;
  adcmc_decode_s decode_cfg;
  logic [47:0] sample_in, sample_out;
  logic [7:0] rd, o;
  logic [7:0] fv [4] = '{8'h80, 8'h05, 8'h1A, 8'h60};
  logic [7:0] cur_tab [8] = '{8'h46, 8'h50, 8'h5A, 8'h00, 8'h3C, 8'h32, 8'h2A, 8'h23};
  logic [4:0] ser_tab [8] = '{5'h10, 5'h0E, 5'h0C, 5'h00, 5'h00, 5'h0E, 5'h0C, 5'h10};
  localparam logic [47:0] SMP = 48'h8017FE3C5A4B;
  int failures, checked;

  // Open-drain line with pull-up
  assign readback_line = serial_readback_oe_n ? 1'b1 : serial_readback_out;

  // Core clock, 100 MHz
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  adcmc_mode_regs dut (.core_clk(core_clk), .rst(rst), .link_sck(link_sck),
    .chip_select_n(chip_select_n), .serial_config_in(serial_config_in),
    .serial_readback_out(serial_readback_out), .serial_readback_oe_n(serial_readback_oe_n),
    .config_port_select(config_port_select), .format_cfg(format_cfg),
    .omode_cfg(omode_cfg), .decode_cfg(decode_cfg), .sample_in(sample_in),
    .sample_valid(sample_valid), .sample_out(sample_out),
    .sample_out_valid(sample_out_valid));

  adcmc_host_model host (.link_sck(link_sck), .chip_select_n(chip_select_n),
    .serial_config_in(serial_config_in), .readback_line(readback_line));

  // ------------------------------------------------------------
  // Access and checking tasks
  // ------------------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    host.frame(1'b0, a, d, 80, r);
    repeat (12) @(negedge core_clk);
  endtask

  task automatic rdb(input logic [6:0] a, output logic [7:0] d);
    host.frame(1'b1, a, 8'hA5, 80, d);
  endtask

  // One sample strobe; output checked one cycle later
  task automatic strobe(input logic [47:0] s);
    @(negedge core_clk);
    sample_in = s;
    sample_valid = 1'b1;
    @(negedge core_clk);
    sample_valid = 1'b0;
  endtask

  // Expected formatted word: sign, scramble, channel gating
  function automatic logic [47:0] fmt(input logic [47:0] s, input logic [7:0] f);
    logic [11:0] w;
    fmt = '0;
    for (int c = 0; c < 4; c++) begin
      w = s[c*12 +: 12];
      if (f[5]) begin
        w[11] = ~w[11];
      end
      if (f[6]) begin
        w[11:1] = w[11:1] ^ {11{w[0]}};
      end
      if (!f[4] && !f[c]) begin
        fmt[c*12 +: 12] = w;
      end
    end
  endfunction

  task automatic wrap_up;
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    #500000;
    failures++;
    wrap_up();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    failures = 0;
    checked = 0;
    rst = 1'b1;
    config_port_select = 1'b0;
    sample_in = '0;
    sample_valid = 1'b0;
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    #37;
    wr(7'h00, 8'h80);
    check(format_cfg, 8'h00);
    check(decode_cfg, {1'b1, 4'hF, 8'h46, 1'b0, 1'b0, 5'h10, 1'b0});
    for (int i = 0; i < 4; i++) begin
      wr(7'h01, fv[i]);
      repeat (100) @(negedge core_clk);
      check(format_cfg, fv[i]);
      check(decode_cfg.duty_stabilizer_on, !fv[i][7]);
      check(decode_cfg.channel_enable, fv[i][4] ? 4'h0 : fv[i][3:0] ^ 4'hF);
      rdb(7'h01, rd);
      check(rd, fv[i]);
      check(format_cfg, fv[i]);
      strobe(SMP);
      check(sample_out_valid, 1'b1);
      check(sample_out, fmt(SMP, fv[i]));
    end
    for (int i = 0; i < 8; i++) begin
      o = {i[2:0], i >= 5, 1'b0, i[2:0]};
      wr(7'h02, o);
      check(omode_cfg, o);
      check(decode_cfg.drive_current, cur_tab[i] << (i >= 5));
      check(decode_cfg.current_code_unused, i == 3);
      check(decode_cfg.serial_bits, ser_tab[i]);
      check(decode_cfg.one_lane, i[2]);
      check(decode_cfg.lane_code_unused, i == 3 || i == 4);
    end
    wr(7'h02, 8'h08);
    strobe(SMP);
    check(sample_out_valid, 1'b0);
    wr(7'h01, 8'h3C);
    wr(7'h00, 8'h7F);
    check(format_cfg, 8'h3C);
    rdb(7'h00, rd);
    check(rd, 8'h00);
    wr(7'h00, 8'hFF);
    check({format_cfg, omode_cfg}, 16'h0000);
    wr(7'h01, 8'h21);
    check(format_cfg, 8'h21);
    wr(7'h03, 8'h55);
    rdb(7'h03, rd);
    check(rd, 8'h00);
    check({format_cfg, omode_cfg}, 16'h2100);
    host.frame(1'b0, 7'h01, 8'h44, 200, rd);
    repeat (12) @(negedge core_clk);
    check(format_cfg, 8'h44);
    config_port_select = 1'b1;
    repeat (4) @(negedge core_clk);
    wr(7'h01, 8'h11);
    check(format_cfg, 8'h44);
    config_port_select = 1'b0;
    wrap_up();
  end
endmodule

// >>> adcmc_pkg.sv
// Types shared by the mode control register bank.
// Assumes adcmc_defs.svh is on the include path.
`include "adcmc_defs.svh"

package adcmc_pkg;

  // Format and power-down register, bit 7 first
  typedef struct packed {
    logic duty_stabilizer_disable;
    logic output_scramble_enable;
    logic signed_format_select;
    logic sleep;
    logic [3:0] nap;
  } adcmc_format_s;

  // Output driver and lane mode register, bit 7 first
  typedef struct packed {
    logic [2:0] driver_current_select;
    logic internal_termination_enable;
    logic output_drive_disable;
    logic [2:0] lane_serialization_select;
  } adcmc_omode_s;

  // Decoded settings for the rest of the chip
  typedef struct packed {
    logic duty_stabilizer_on;
    logic [3:0] channel_enable;
    logic [7:0] drive_current;
    logic current_code_unused;
    logic one_lane;
    logic [4:0] serial_bits;
    logic lane_code_unused;
  } adcmc_decode_s;

  // Link phase, one-hot
  typedef enum logic [3:0] {
    ADCMC_LK_HEAD = 4'h1,
    ADCMC_LK_WRITE = 4'h2,
    ADCMC_LK_READ = 4'h4,
    ADCMC_LK_DONE = 4'h8
  } adcmc_link_e;

endpackage

// >>> adcmc_sync2.sv
// Two-stage synchronizer for level signals.
// Assumes each bit changes at most once per destination clock pair.
`timescale 1ns/10ps

module adcmc_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    stage1_reg <= async_in;
    sync_out <= stage1_reg;
  end

endmodule
